// File: sfm_pkg.sv
package sfm_pkg;
   localparam int SFM_CHANNELS = 2;
   localparam int SFM_SYNC_STAGES = 2;
   localparam logic SFM_OV_DISABLE_RST = 1'b0;
   localparam logic SFM_FLAG_RST = 1'b0;
   localparam logic [1:0] SFM_CH_OFF = 2'h0;
   // Bit positions in the readable fault vector
   localparam int SFM_FLT_OV = 0;
   localparam int SFM_FLT_UV = 1;
   localparam int SFM_FLT_OT0 = 2;
   localparam int SFM_FLT_OT1 = 3;
   localparam int SFM_FLT_OC0 = 4;
   localparam int SFM_FLT_OC1 = 5;
   localparam int SFM_FLT_SC0 = 6;
   localparam int SFM_FLT_SC1 = 7;
   localparam int SFM_FLT_W = 8;
   typedef enum logic [1:0] {SFM_NORMAL, SFM_OV_SHUT, SFM_UV_SHUT, SFM_FAILSAFE} sfm_state_t;
endpackage

// File: sfm_sync.sv
`timescale 1ns/1ps
module sfm_sync
   import sfm_pkg::*;
(
   input wire logic clk,     // Clock
   input wire logic rst_n,   // Async reset
   input wire logic ce,      // Clock enable
   input wire logic d_async, // Asynchronous level
   output logic q            // Synchronised level
);
   logic meta_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= 1'b0;
         q <= 1'b0;
      end else if (ce) begin
         meta_reg <= d_async;
         q <= meta_reg;
      end
   end
endmodule

// File: sfm_core.sv
`timescale 1ns/1ps
module sfm_core
   import sfm_pkg::*;
(
   input wire logic clk,                  // 100 MHz clock
   input wire logic rst_n,                // Power-on reset, active low
   input wire logic ce,                   // Clock enable
   input wire logic ov_cmp,               // Overvoltage comparator, async
   input wire logic ov_hys_cmp,           // Supply above OV minus hysteresis, async
   input wire logic uv_cmp,               // Supply below undervoltage, async
   input wire logic deep_uv_cmp,          // Supply below extended low limit, async
   input wire logic load_gnd_loss,        // Load ground lost, async
   input wire logic sys_gnd_loss,         // System ground lost, async
   input wire logic gnd_high,             // Device ground at logic high, async
   input wire logic logic_supply_fail,    // Logic supply failed, async
   input wire logic overvoltage_disable,  // Config bit from general_config_reg
   input wire logic [1:0] on_request,     // Channel on requests (hson)
   input wire logic [1:0] direct_in,      // Direct input pins, async
   input wire logic [1:0] ot_fault,       // Overtemperature per channel
   input wire logic [1:0] oc_fault,       // Overcurrent per channel
   input wire logic [1:0] sc_fault,       // Short-circuit per channel
   input wire logic [1:0] retry_enable,   // Auto-retry enabled per channel
   input wire logic delatch,              // Delatch sequence pulse
   input wire logic status_read,          // Status register read strobe
   output logic [1:0] switch_output,      // Channel gate enables
   output logic [1:0] fast_off,           // Bypass slew-rate on turn-off
   output logic fault_status_n,           // Fault status pin, low on fault
   output logic overvoltage_flag,         // Overvoltage flag
   output logic undervoltage_flag,        // Common undervoltage flag
   output logic [1:0] overtemp_flag,      // Overtemperature flags
   output logic [1:0] overcurrent_flag,   // Overcurrent flags
   output logic [1:0] short_circuit_flag, // Short-circuit flags
   output logic [1:0] open_load_flag,     // Open-load flags
   output logic [1:0] retry_cond,         // Retry condition per channel
   output logic [1:0] retry_start,        // One-cycle retry start pulse
   output logic failsafe,                 // Fail-safe mode active
   output logic regs_reset                // Reset to serial registers
);
   logic ov_s, ovh_s, uv_s, duv_s, lgl_s, sgl_s, gh_s, lsf_s;
   logic [1:0] din_s;
   logic uv_d_reg;
   logic uv_warn_reg;
   logic [1:0] armed_reg;
   logic [1:0] ot_pend_reg;
   logic [1:0] ot_vis;
   logic ov_shut_reg;
   logic clr_all;
   logic uv_fall;
   logic [1:0] ch_next;
   logic fs_next;
   sfm_state_t state_reg, state_next;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_sync
         logic a, y;
         always_comb begin
            case (gi)
               0: a = ov_cmp;
               1: a = ov_hys_cmp;
               2: a = uv_cmp;
               3: a = deep_uv_cmp;
               4: a = load_gnd_loss;
               5: a = sys_gnd_loss;
               6: a = gnd_high;
               default: a = logic_supply_fail;
            endcase
         end
         sfm_sync u_sync (
            .clk(clk),
            .rst_n(rst_n),
            .ce(ce),
            .d_async(a),
            .q(y)
         );
      end
      for (gi = 0; gi < SFM_CHANNELS; gi++) begin : g_din
         sfm_sync u_sync (
            .clk(clk),
            .rst_n(rst_n),
            .ce(ce),
            .d_async(direct_in[gi]),
            .q(din_s[gi])
         );
      end
   endgenerate
   assign ov_s = g_sync[0].y;
   assign ovh_s = g_sync[1].y;
   assign uv_s = g_sync[2].y;
   assign duv_s = g_sync[3].y;
   assign lgl_s = g_sync[4].y;
   assign sgl_s = g_sync[5].y;
   assign gh_s = g_sync[6].y;
   assign lsf_s = g_sync[7].y;

   // Loss of logic supply clears faults
   assign clr_all = lsf_s;
   assign uv_fall = uv_d_reg & ~uv_s;
   // High ground shift means link lost
   assign fs_next = gh_s | lsf_s;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         uv_d_reg <= 1'b0;
      end else if (ce) begin
         uv_d_reg <= uv_s;
      end
   end

   // Recovery with all requests idle is only a warning
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         uv_warn_reg <= 1'b0;
      end else if (ce) begin
         if (uv_s) begin
            uv_warn_reg <= 1'b0;
         end else if (uv_fall) begin
            uv_warn_reg <= (on_request == SFM_CH_OFF);
         end
      end
   end

   // Protection state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SFM_NORMAL: begin
            if (fs_next) begin
               state_next = SFM_FAILSAFE;
            end else if (uv_s) begin
               state_next = SFM_UV_SHUT;
            end else if (ov_s && !overvoltage_disable) begin
               state_next = SFM_OV_SHUT;
            end
         end
         SFM_OV_SHUT: begin
            if (fs_next) begin
               state_next = SFM_FAILSAFE;
            end else if (uv_s) begin
               state_next = SFM_UV_SHUT;
            end else if (!ovh_s || overvoltage_disable) begin
               state_next = SFM_NORMAL;
            end
         end
         SFM_UV_SHUT: begin
            if (fs_next) begin
               state_next = SFM_FAILSAFE;
            end else if (!uv_s) begin
               state_next = SFM_NORMAL;
            end
         end
         SFM_FAILSAFE: begin
            if (!fs_next) begin
               state_next = SFM_NORMAL;
            end
         end
         default: state_next = SFM_NORMAL;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= SFM_NORMAL;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   assign failsafe = (state_reg == SFM_FAILSAFE);
   assign ov_shut_reg = (state_reg == SFM_OV_SHUT);
   // Serial registers held reset in fail-safe
   assign regs_reset = failsafe;

   // Channel re-armed after undervoltage by delatch or by its on request going low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_reg <= 2'h3;
      end else if (ce) begin
         for (int i = 0; i < SFM_CHANNELS; i++) begin
            if (delatch || !on_request[i]) begin
               armed_reg[i] <= 1'b1;
            end else if (uv_s) begin
               armed_reg[i] <= 1'b0;
            end
         end
      end
   end

   // Channel drive
   always_comb begin
      ch_next = on_request & armed_reg;
      if (failsafe) begin
         ch_next = din_s;
      end
      if (ov_shut_reg || uv_s || sgl_s || duv_s) begin
         ch_next = SFM_CH_OFF;
      end
      ch_next = ch_next & ~(oc_fault | sc_fault | ot_fault);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         switch_output <= SFM_CH_OFF;
         fast_off <= 2'h0;
      end else if (ce) begin
         switch_output <= ch_next;
         fast_off <= oc_fault | sc_fault | ot_fault | {2{uv_s}};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         overvoltage_flag <= SFM_FLAG_RST;
      end else if (ce) begin
         if (ov_s) begin
            overvoltage_flag <= 1'b1;
         end else if (clr_all || failsafe) begin
            overvoltage_flag <= 1'b0;
         end else if (status_read && !ovh_s) begin
            overvoltage_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         undervoltage_flag <= SFM_FLAG_RST;
      end else if (ce) begin
         if (uv_s) begin
            undervoltage_flag <= 1'b1;
         end else if (clr_all || failsafe) begin
            undervoltage_flag <= 1'b0;
         end else if (switch_output == SFM_CH_OFF && ch_next != SFM_CH_OFF && !uv_d_reg && uv_warn_reg) begin
            undervoltage_flag <= 1'b0;
         // Read clears only with cause gone
         end else if (status_read) begin
            undervoltage_flag <= 1'b0;
         end
      end
   end

   // Overtemp held pending during undervoltage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ot_pend_reg <= 2'h0;
      end else if (ce) begin
         if (clr_all || failsafe) begin
            ot_pend_reg <= 2'h0;
         end else if (uv_s) begin
            ot_pend_reg <= ot_pend_reg | ot_fault;
         end else begin
            ot_pend_reg <= 2'h0;
         end
      end
   end
   assign ot_vis = uv_s ? 2'h0 : (ot_fault | ot_pend_reg);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         overtemp_flag <= 2'h0;
         overcurrent_flag <= 2'h0;
         short_circuit_flag <= 2'h0;
         open_load_flag <= 2'h0;
      end else if (ce) begin
         for (int i = 0; i < SFM_CHANNELS; i++) begin
            if (ot_vis[i]) begin
               overtemp_flag[i] <= 1'b1;
            end else if (clr_all || failsafe || (status_read && fault_status_n)) begin
               overtemp_flag[i] <= 1'b0;
            end
            if (oc_fault[i]) begin
               overcurrent_flag[i] <= 1'b1;
            end else if (clr_all || failsafe || status_read) begin
               overcurrent_flag[i] <= 1'b0;
            end
            if (sc_fault[i]) begin
               short_circuit_flag[i] <= 1'b1;
            end else if (clr_all || failsafe || status_read) begin
               short_circuit_flag[i] <= 1'b0;
            end
            // Load ground loss flags open load
            if (lgl_s && on_request[i]) begin
               open_load_flag[i] <= 1'b1;
            end else if (clr_all || failsafe || status_read) begin
               open_load_flag[i] <= 1'b0;
            end
         end
      end
   end

   assign retry_cond = overcurrent_flag | short_circuit_flag | overtemp_flag | {2{undervoltage_flag}};

   // Retry launched as undervoltage goes away
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         retry_start <= 2'h0;
      end else if (ce) begin
         retry_start <= {2{uv_fall}} & retry_enable;
      end
   end

   // Fault pin low during OV or UV shutdown or any OT, OC or SC fault
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_status_n <= 1'b1;
      end else if (ce) begin
         fault_status_n <= ~((state_next == SFM_OV_SHUT) || uv_s || (|(oc_fault | sc_fault | ot_fault)));
      end
   end
endmodule

// File: sfm_core_properties.sv
`timescale 1ns/1ps
module sfm_core_properties
   import sfm_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset
   input wire logic ov_cmp, // OV comparator
   input wire logic ov_hys_cmp, // Above hysteresis
   input wire logic uv_cmp, // UV comparator
   input wire logic gnd_high, // Ground shift
   input wire logic overvoltage_disable, // OV disable
   input wire logic [1:0] on_request, // On requests
   input wire logic [1:0] retry_enable, // Retry enables
   input wire logic status_read, // Read strobe
   input wire logic [1:0] switch_output, // Channels
   input wire logic fault_status_n, // Fault pin
   input wire logic overvoltage_flag, // OV flag
   input wire logic undervoltage_flag, // UV flag
   input wire logic [1:0] overtemp_flag, // OT flags
   input wire logic [1:0] overcurrent_flag, // OC flags
   input wire logic [1:0] short_circuit_flag, // SC flags
   input wire logic [1:0] retry_cond, // Retry condition
   input wire logic [1:0] retry_start, // Retry pulse
   input wire logic failsafe // Fail-safe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_ov_off;
      (ov_cmp && !overvoltage_disable)[*3] |-> ##[0:3] (switch_output == SFM_CH_OFF && !fault_status_n);
   endproperty
   a_ov_off: assert property (p_ov_off) else $error("ov shutdown missing");
   property p_ov_flag;
      ov_cmp[*3] |-> ##[0:3] overvoltage_flag;
   endproperty
   a_ov_flag: assert property (p_ov_flag) else $error("ov flag not set");
   property p_ov_hold;
      (ov_cmp && !overvoltage_disable)[*4] ##1 (!ov_cmp && ov_hys_cmp)[*4] |-> switch_output == SFM_CH_OFF;
   endproperty
   a_ov_hold: assert property (p_ov_hold) else $error("channel on above hysteresis");
   property p_rd_keep;
      ov_cmp[*4] ##0 status_read |=> overvoltage_flag;
   endproperty
   a_rd_keep: assert property (p_rd_keep) else $error("flag cleared with cause present");
   property p_uv_off;
      uv_cmp[*3] |-> ##[0:3] (switch_output == SFM_CH_OFF && undervoltage_flag && !fault_status_n);
   endproperty
   a_uv_off: assert property (p_uv_off) else $error("uv shutdown missing");
   property p_uv_idle;
      uv_cmp[*4] ##1 (!uv_cmp && on_request == 2'h0 && !ov_cmp)[*6] |-> fault_status_n && undervoltage_flag;
   endproperty
   a_uv_idle: assert property (p_uv_idle) else $error("idle uv recovery wrong");
   property p_retry;
      uv_cmp[*4] ##1 (!uv_cmp && retry_enable[0]) |-> ##[0:4] retry_start[0];
   endproperty
   a_retry: assert property (p_retry) else $error("retry not started");
   property p_rc;
      retry_cond[0] |-> (overcurrent_flag[0] || short_circuit_flag[0] || overtemp_flag[0] || undervoltage_flag);
   endproperty
   a_rc: assert property (p_rc) else $error("retry condition without fault");
   property p_fs;
      gnd_high[*3] |-> ##[0:3] failsafe;
   endproperty
   a_fs: assert property (p_fs) else $error("fail-safe not entered");
endmodule

// File: sfm_host_model.sv
`timescale 1ns/1ps
module sfm_host_model (
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset
   input wire logic rd_req, // Read request level
   output logic status_read // One-cycle read strobe
);
   logic req_reg;
   // One strobe per rising request edge, as one SPI frame completing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_reg <= 1'b0;
         status_read <= 1'b0;
      end else begin
         req_reg <= rd_req;
         status_read <= rd_req && !req_reg;
      end
   end
endmodule

// File: sfm_core_tb_top.sv
`timescale 1ns/1ps
module sfm_core_tb_top;
   import sfm_pkg::*;
   logic clk = 0, rst_n = 0, ov = 0, hys = 0, uv = 0, gh = 0, lsf = 0, dis = 0, dl = 0, rd_req = 0, rd, rs_seen = 0;
   logic [1:0] req = 2'h0, ot = 2'h0, oc = 2'h0, sc = 2'h0, re = 2'h0;
   logic duv = 0, lgl = 0, sgl = 0;
   logic [1:0] din = 2'h0;
   logic [1:0] so, fo, otf, ocf, scf, olf, rc, rs;
   logic fsn, ovf, uvf, fs, rr;
   int errors = 0, samples_checked = 0;
   always #5 clk = ~clk;
   always @(posedge clk) if (rs[0]) rs_seen <= 1'b1;
   sfm_host_model i_host (.clk(clk), .rst_n(rst_n), .rd_req(rd_req), .status_read(rd));
   sfm_core i_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .ov_cmp(ov), .ov_hys_cmp(hys), .uv_cmp(uv),
      .deep_uv_cmp(duv), .load_gnd_loss(lgl), .sys_gnd_loss(sgl), .gnd_high(gh), .logic_supply_fail(lsf),
      .overvoltage_disable(dis), .on_request(req), .direct_in(din), .ot_fault(ot), .oc_fault(oc), .sc_fault(sc),
      .retry_enable(re), .delatch(dl), .status_read(rd), .switch_output(so), .fast_off(fo), .fault_status_n(fsn),
      .overvoltage_flag(ovf), .undervoltage_flag(uvf), .overtemp_flag(otf), .overcurrent_flag(ocf),
      .short_circuit_flag(scf), .open_load_flag(olf), .retry_cond(rc), .retry_start(rs), .failsafe(fs),
      .regs_reset(rr));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rd_status();
      rd_req = 1'b1;
      cyc(1);
      rd_req = 1'b0;
      cyc(4);
   endtask
   function automatic logic [7:0] st();
      return {3'h0, fsn, ovf, uvf, so};
   endfunction
   task automatic summarize();
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #200000;
      errors++;
      summarize();
   end
   initial begin
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      cyc(3);
      chk(st(), 8'h10);
      chk({6'h0, fs, rr}, 8'h00);
      req = 2'h3;
      cyc(6);
      chk(st(), 8'h13);
      ov = 1'b1;
      hys = 1'b1;
      cyc(6);
      chk(st(), 8'h08);
      rd_status();
      chk({7'h0, ovf}, 8'h01);
      ov = 1'b0;
      cyc(6);
      chk({6'h0, so}, 8'h00);
      rd_status();
      chk({7'h0, ovf}, 8'h01);
      hys = 1'b0;
      cyc(6);
      rd_status();
      chk({7'h0, ovf}, 8'h00);
      dis = 1'b1;
      req = 2'h0;
      cyc(2);
      req = 2'h3;
      cyc(6);
      ov = 1'b1;
      hys = 1'b1;
      cyc(6);
      chk(st(), 8'h1B);
      ov = 1'b0;
      hys = 1'b0;
      cyc(6);
      dis = 1'b0;
      rd_status();
      chk({7'h0, ovf}, 8'h00);
      req = 2'h0;
      cyc(2);
      uv = 1'b1;
      cyc(6);
      chk(st(), 8'h04);
      uv = 1'b0;
      cyc(8);
      chk(st(), 8'h14);
      req = 2'h3;
      cyc(6);
      chk(st(), 8'h13);
      re = 2'h3;
      uv = 1'b1;
      cyc(6);
      chk(st(), 8'h04);
      uv = 1'b0;
      cyc(8);
      chk({7'h0, rs_seen}, 8'h01);
      chk({6'h0, so}, 8'h00);
      re = 2'h0;
      dl = 1'b1;
      cyc(1);
      dl = 1'b0;
      cyc(6);
      chk(st(), 8'h17);
      rd_status();
      chk({7'h0, uvf}, 8'h00);
      oc = 2'h1;
      cyc(4);
      chk({2'h0, ocf, rc, so}, 8'h16);
      chk({6'h0, fo}, 8'h01);
      oc = 2'h0;
      cyc(2);
      dl = 1'b1;
      cyc(1);
      dl = 1'b0;
      cyc(4);
      rd_status();
      chk({6'h0, ocf}, 8'h00);
      uv = 1'b1;
      cyc(6);
      uv = 1'b0;
      cyc(8);
      gh = 1'b1;
      din = 2'h2;
      cyc(6);
      chk({5'h0, fs, rr, uvf}, 8'h06);
      chk({6'h0, so}, 8'h02);
      gh = 1'b0;
      din = 2'h0;
      cyc(6);
      lsf = 1'b1;
      cyc(6);
      chk({7'h0, fs}, 8'h01);
      lsf = 1'b0;
      cyc(6);
      dl = 1'b1;
      cyc(1);
      dl = 1'b0;
      cyc(4);
      lgl = 1'b1;
      sc = 2'h2;
      cyc(2);
      sc = 2'h0;
      cyc(4);
      chk({2'h0, scf, olf, so}, 8'h2F);
      lgl = 1'b0;
      sgl = 1'b1;
      cyc(6);
      chk({6'h0, so}, 8'h00);
      sgl = 1'b0;
      cyc(6);
      rd_status();
      chk({4'h0, scf, olf}, 8'h00);
      uv = 1'b1;
      duv = 1'b1;
      cyc(4);
      ot = 2'h1;
      cyc(2);
      ot = 2'h0;
      cyc(2);
      chk({2'h0, otf, fo, so}, 8'h0C);
      uv = 1'b0;
      duv = 1'b0;
      cyc(6);
      chk({6'h0, otf}, 8'h01);
      rd_status();
      chk({6'h0, otf}, 8'h00);
      summarize();
   end
endmodule
bind sfm_core sfm_core_properties i_props (.clk, .rst_n, .ov_cmp, .ov_hys_cmp, .uv_cmp, .gnd_high,
   .overvoltage_disable, .on_request, .retry_enable, .status_read, .switch_output, .fault_status_n,
   .overvoltage_flag, .undervoltage_flag, .overtemp_flag, .overcurrent_flag, .short_circuit_flag,
   .retry_cond, .retry_start, .failsafe);
